// [bench/tb_ais_top.sv]
// Self-checking bench for the converter input select block
`timescale 1ns/1ps
`default_nettype none
`include "ais_map.svh"
module tb_ais_top;
	localparam int PHYS = 24;
	logic        ref_clk, rst;
	logic [7:0]  awaddr, araddr;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata, pin_digital;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, conv_done, pos_use_vref_neg, pos_to_ground;
	logic [1:0]  neg_use_an1, sample_b_active;
	logic [9:0]  pos_input;
	int          errors, tests_run;

	ais_top #(.PHYS_INPUTS(PHYS)) u_dut (
		.ref_clk(ref_clk), .rst(rst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.conv_done(conv_done), .pos_input(pos_input), .pos_use_vref_neg(pos_use_vref_neg),
		.pos_to_ground(pos_to_ground), .neg_use_an1(neg_use_an1),
		.sample_b_active(sample_b_active), .pin_digital(pin_digital)
	);

	task automatic finish_test();
		$display("Checks run %0d, mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : finish_test

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp)
		begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Ready is sampled on the falling edge so the handshake edge is judged on settled values
	task automatic wchk(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
		logic       aw_ok, w_ok, b_ok;
		logic [1:0] r;
		int         n;
		@(posedge ref_clk);
		n = 0;
		b_ok = 1'b0;
		awaddr  <= a;
		wdata   <= {16'h0000, d};
		wstrb   <= 4'hf;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		while (!b_ok && n < 50)
		begin
			@(negedge ref_clk);
			aw_ok = awvalid && awready;
			w_ok = wvalid && wready;
			b_ok = bvalid;
			r = bresp;
			@(posedge ref_clk);
			if (aw_ok)
				awvalid <= 1'b0;
			if (w_ok)
				wvalid <= 1'b0;
			n++;
		end
		bready <= 1'b0;
		chk("write answer", 32'h1, {31'h0, b_ok});
		chk("write response", {30'h0, er}, {30'h0, r});
	endtask : wchk

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		logic        ar_ok, r_ok;
		logic [31:0] d;
		logic [1:0]  r;
		int          n;
		@(posedge ref_clk);
		n = 0;
		r_ok = 1'b0;
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		while (!r_ok && n < 50)
		begin
			@(negedge ref_clk);
			ar_ok = arvalid && arready;
			r_ok = rvalid;
			d = rdata;
			r = rresp;
			@(posedge ref_clk);
			if (ar_ok)
				arvalid <= 1'b0;
			n++;
		end
		rready <= 1'b0;
		chk("read answer", 32'h1, {31'h0, r_ok});
		chk("read data", exp, d);
		chk("read response", {30'h0, er}, {30'h0, r});
	endtask : rchk

	task automatic settle();
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask : settle

	// One finished conversion on the first converter
	task automatic pulse();
		@(posedge ref_clk);
		conv_done <= 2'b01;
		@(posedge ref_clk);
		conv_done <= 2'b00;
		settle();
	endtask : pulse

	task automatic t_reset();
		logic [7:0] offs [10] = '{`AIS_OFF_CHS0_1, `AIS_OFF_SCANH_1, `AIS_OFF_SCANL_1,
			`AIS_OFF_PCFGH_1, `AIS_OFF_PCFGL_1, `AIS_OFF_CHS0_2, `AIS_OFF_SCANH_2,
			`AIS_OFF_SCANL_2, `AIS_OFF_PCFGL_2, `AIS_OFF_CTRL};
		settle();
		chk("pins after reset", 32'hffffffff << PHYS, pin_digital);
		chk("pos after reset", 32'h0, {22'h0, pos_input});
		foreach (offs[i])
			rchk(offs[i], {16'h0000, `AIS_RST_REG}, `AIS_RESP_OKAY);
	endtask : t_reset

	task automatic t_select();
		logic [4:0] vals [5] = '{5'd0, 5'd1, 5'd16, 5'd23, 5'd24};
		wchk(`AIS_OFF_CHS0_1, 16'hffff, `AIS_RESP_OKAY);
		rchk(`AIS_OFF_CHS0_1, 32'h9f9f, `AIS_RESP_OKAY);
		wchk(`AIS_OFF_CHS0_2, 16'hffff, `AIS_RESP_OKAY);
		rchk(`AIS_OFF_CHS0_2, 32'h8f8f, `AIS_RESP_OKAY);
		settle();
		chk("pos both", {22'h0, 5'd15, 5'd31}, {22'h0, pos_input});
		chk("neg both", 32'h3, {30'h0, neg_use_an1});
		chk("missing pin", 32'h1, {30'h0, pos_use_vref_neg});
		foreach (vals[i])
		begin
			wchk(`AIS_OFF_CHS0_1, {11'h000, vals[i]}, `AIS_RESP_OKAY);
			settle();
			chk("pos a", {27'h0, vals[i]}, {27'h0, pos_input[4:0]});
			chk("vref a", {31'h0, vals[i] >= PHYS}, {31'h0, pos_use_vref_neg[0]});
			chk("neg a", 32'h0, {31'h0, neg_use_an1[0]});
		end
	endtask : t_select

	task automatic t_masks();
		wchk(`AIS_OFF_SCANH_1, 16'ha5a5, `AIS_RESP_OKAY);
		rchk(`AIS_OFF_SCANH_1, 32'ha5a5, `AIS_RESP_OKAY);
		wchk(`AIS_OFF_SCANL_2, 16'h5a5a, `AIS_RESP_OKAY);
		rchk(`AIS_OFF_SCANL_2, 32'h5a5a, `AIS_RESP_OKAY);
		wchk(8'h2c, 16'h1234, `AIS_RESP_SLVERR);
		rchk(8'h2c, 32'h0, `AIS_RESP_SLVERR);
	endtask : t_masks

	task automatic t_pins();
		wchk(`AIS_OFF_PCFGL_1, 16'h00ff, `AIS_RESP_OKAY);
		settle();
		chk("one low cfg", 32'hffffffff << PHYS, pin_digital);
		wchk(`AIS_OFF_PCFGL_2, 16'h000f, `AIS_RESP_OKAY);
		wchk(`AIS_OFF_PCFGH_1, 16'hffff, `AIS_RESP_OKAY);
		rchk(`AIS_OFF_PCFGH_1, 32'hffff, `AIS_RESP_OKAY);
		settle();
		chk("both cfg", 32'hffff000f, pin_digital);
		wchk(`AIS_OFF_CHS0_1, 16'h0002, `AIS_RESP_OKAY);
		settle();
		chk("digital input", 32'h1, {31'h0, pos_to_ground[0]});
		wchk(`AIS_OFF_CHS0_1, 16'h0009, `AIS_RESP_OKAY);
		settle();
		chk("analog input", 32'h0, {31'h0, pos_to_ground[0]});
		wchk(`AIS_OFF_CTRL, 16'h0044, `AIS_RESP_OKAY);
		settle();
		chk("disabled pins", 32'hffffffff, pin_digital);
		chk("disabled mux", 32'h1, {31'h0, pos_to_ground[0]});
		wchk(`AIS_OFF_CTRL, 16'h0000, `AIS_RESP_OKAY);
		wchk(`AIS_OFF_PCFGL_1, 16'h0000, `AIS_RESP_OKAY);
		wchk(`AIS_OFF_PCFGL_2, 16'h0000, `AIS_RESP_OKAY);
	endtask : t_pins

	task automatic t_alt();
		wchk(`AIS_OFF_CHS0_1, 16'h9a05, `AIS_RESP_OKAY);
		wchk(`AIS_OFF_CTRL, 16'h0001, `AIS_RESP_OKAY);
		settle();
		chk("first is a", 32'h0, {31'h0, sample_b_active[0]});
		chk("pos a", 32'd5, {27'h0, pos_input[4:0]});
		pulse();
		chk("second is b", 32'h1, {31'h0, sample_b_active[0]});
		chk("pos b", 32'd26, {27'h0, pos_input[4:0]});
		chk("neg b", 32'h1, {31'h0, neg_use_an1[0]});
		chk("vref b", 32'h1, {31'h0, pos_use_vref_neg[0]});
		pulse();
		chk("third is a", 32'd5, {27'h0, pos_input[4:0]});
		chk("neg a again", 32'h0, {31'h0, neg_use_an1[0]});
		wchk(`AIS_OFF_CTRL, 16'h0000, `AIS_RESP_OKAY);
	endtask : t_alt

	task automatic t_scan();
		wchk(`AIS_OFF_CHS0_1, 16'h0001, `AIS_RESP_OKAY);
		wchk(`AIS_OFF_SCANL_1, 16'h0028, `AIS_RESP_OKAY);
		wchk(`AIS_OFF_SCANH_1, 16'h4000, `AIS_RESP_OKAY);
		wchk(`AIS_OFF_CTRL, 16'h0002, `AIS_RESP_OKAY);
		settle();
		chk("scan first", 32'd3, {27'h0, pos_input[4:0]});
		pulse();
		chk("scan second", 32'd5, {27'h0, pos_input[4:0]});
		pulse();
		chk("scan high", 32'd30, {27'h0, pos_input[4:0]});
		chk("scan no pin", 32'h1, {31'h0, pos_use_vref_neg[0]});
		rchk(`AIS_OFF_STAT, 32'h011e, `AIS_RESP_OKAY);
		pulse();
		chk("scan wrap", 32'd3, {27'h0, pos_input[4:0]});
		wchk(`AIS_OFF_CTRL, 16'h0000, `AIS_RESP_OKAY);
		settle();
		chk("scan off", 32'd1, {27'h0, pos_input[4:0]});
	endtask : t_scan

	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// Whole run needs a few hundred cycles; this leaves ample margin
	initial
	begin
		#300000;
		errors++;
		$display("[FAIL] watchdog expected done seen hang");
		finish_test();
	end

	initial
	begin
		errors = 0;
		tests_run = 0;
		rst = 1'b1;
		awaddr = 8'h00;
		araddr = 8'h00;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		wdata = 32'h0;
		wstrb = 4'h0;
		conv_done = 2'b00;
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		t_reset();
		t_select();
		t_masks();
		t_pins();
		t_alt();
		t_scan();
		finish_test();
	end
endmodule : tb_ais_top
`default_nettype wire

// [hw/ais_axil_slave.sv]
// AXI4-Lite slave front end: captures writes and registers read data
`timescale 1ns/1ps
`default_nettype none
`include "ais_map.svh"
module ais_axil_slave (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             wr_en,
	output logic [7:0]       wr_addr,
	output logic [15:0]      wr_data,
	output logic [1:0]       wr_strb,
	input  wire logic        wr_err,
	output logic [7:0]       rd_addr,
	input  wire logic [15:0] rd_data,
	input  wire logic        rd_err
);
	ais_pkg::ais_slv_t s_q, s_d;

	assign s_axi_awready = !s_q.aw_got && !s_q.bvalid;
	assign s_axi_wready  = !s_q.w_got && !s_q.bvalid;
	assign s_axi_arready = !s_q.rvalid;
	assign s_axi_bvalid  = s_q.bvalid;
	assign s_axi_bresp   = s_q.bresp;
	assign s_axi_rvalid  = s_q.rvalid;
	assign s_axi_rresp   = s_q.rresp;
	assign s_axi_rdata   = s_q.rdata;
	// The write lands one cycle after both halves are held
	assign wr_en   = s_q.aw_got && s_q.w_got && !s_q.bvalid;
	assign wr_addr = s_q.awaddr;
	assign wr_data = s_q.wdata;
	assign wr_strb = s_q.wstrb;
	assign rd_addr = s_axi_araddr;

	always_comb
	begin
		s_d = s_q;
		if (s_axi_awvalid && s_axi_awready)
		begin
			s_d.aw_got = 1'b1;
			s_d.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			s_d.w_got = 1'b1;
			s_d.wdata = s_axi_wdata[15:0];
			s_d.wstrb = s_axi_wstrb[1:0];
		end
		if (wr_en)
		begin
			s_d.aw_got = 1'b0;
			s_d.w_got  = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp  = wr_err ? `AIS_RESP_SLVERR : `AIS_RESP_OKAY;
		end
		if (s_q.bvalid && s_axi_bready)
			s_d.bvalid = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			s_d.rvalid = 1'b1;
			s_d.rdata  = {16'h0000, rd_data};
			s_d.rresp  = rd_err ? `AIS_RESP_SLVERR : `AIS_RESP_OKAY;
		end
		else if (s_q.rvalid && s_axi_rready)
			s_d.rvalid = 1'b0;
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end
endmodule : ais_axil_slave
`default_nettype wire

// [hw/ais_map.svh]
// Register offsets, field positions and reset values of the input select block
`ifndef AIS_MAP_SVH
`define AIS_MAP_SVH
`define AIS_OFF_CHS0_1   8'h00
`define AIS_OFF_SCANH_1  8'h04
`define AIS_OFF_SCANL_1  8'h08
`define AIS_OFF_PCFGH_1  8'h0c
`define AIS_OFF_PCFGL_1  8'h10
`define AIS_OFF_CHS0_2   8'h14
`define AIS_OFF_SCANH_2  8'h18
`define AIS_OFF_SCANL_2  8'h1c
`define AIS_OFF_PCFGL_2  8'h20
`define AIS_OFF_CTRL     8'h24
`define AIS_OFF_STAT     8'h28
`define AIS_NEG_A_BIT    7
`define AIS_NEG_B_BIT    15
`define AIS_POS_A_LSB    0
`define AIS_POS_B_LSB    8
`define AIS_CHS0_MASK_1  16'h9f9f
`define AIS_CHS0_MASK_2  16'h8f8f
`define AIS_CTRL_MASK    16'h0077
`define AIS_CTRL_ALT     0
`define AIS_CTRL_SCAN    1
`define AIS_CTRL_DIS     2
`define AIS_CTRL_STRIDE  4
`define AIS_STAT_STRIDE  8
`define AIS_RST_REG      16'h0000
`define AIS_RESP_OKAY    2'h0
`define AIS_RESP_SLVERR  2'h2
`endif

// [hw/ais_pkg.sv]
// Types shared by the input select block
package ais_pkg;
	typedef enum {
		AIS_R_CHS0_1, AIS_R_SCANH_1, AIS_R_SCANL_1, AIS_R_PCFGH_1, AIS_R_PCFGL_1,
		AIS_R_CHS0_2, AIS_R_SCANH_2, AIS_R_SCANL_2, AIS_R_PCFGL_2,
		AIS_R_CTRL, AIS_R_STAT, AIS_R_NONE
	} ais_reg_t;

	typedef struct packed {
		logic        aw_got;
		logic [7:0]  awaddr;
		logic        w_got;
		logic [15:0] wdata;
		logic [1:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
	} ais_slv_t;
endpackage : ais_pkg

// [hw/ais_scan_step.sv]
// Finds the lowest enabled scan input and the next one above the current
`timescale 1ns/1ps
`default_nettype none
module ais_scan_step (
	input  wire logic [31:0] mask,
	input  wire logic [4:0]  cur,
	output logic [4:0]       first,
	output logic [4:0]       next,
	output logic             any
);
	logic       above;
	logic [4:0] up;

	always_comb
	begin
		first = 5'h00;
		up    = 5'h00;
		above = 1'b0;
		any   = |mask;
		// Scan downward so the lowest hit is the one that stays
		for (int i = 31; i >= 0; i--)
		begin
			if (mask[i])
				first = 5'(i);
			if (mask[i] && (5'(i) > cur))
			begin
				up    = 5'(i);
				above = 1'b1;
			end
		end
		next = above ? up : first;
	end
endmodule : ais_scan_step
`default_nettype wire

// [hw/ais_top.sv]
// Channel 0 input select, scan mask and pin analog configuration for two converters
`timescale 1ns/1ps
`default_nettype none
`include "ais_map.svh"
//
// Function
// R01 - Sample A negative select bit: 1 picks input 1, 0 picks negative reference.
// R02 - Sample B negative select at bit 15, same encoding as Sample A.
// R03 - Sample A five-bit positive select picks input n, 0 to 31.
// R04 - Sample B positive select in bits 12..8, decoded like Sample A.
// R05 - Second converter may only pick inputs 0 to 15 as positive input.
// R06 - Select register bits 14..13 and 6..5 ignore writes, read zero.
// R07 - Each of 32 scan mask bits includes its input in the scan when set.
// R08 - Mask bits always writable; a scanned input without pin converts negative reference.
// R09 - Configuration bit 1: pin digital, read input on, converter mux to ground.
// R10 - Configuration bit 0: pin analog, read input off, converter samples pin.
// R11 - All configuration bits stay read/write; bits without a pin do nothing. Here a selected input without pin still takes pos_to_ground from its bit.
// R12 - Second converter has no high-half pin configuration register.
// R13 - Both low configuration registers together set modes of pins 0 to 15.
// R14 - A disabled converter's configuration bits are ignored; its pins go digital.
// R15 - All implemented bits clear to zero at reset, pins analog.
// R16 - Scan enable takes Sample A positive input from the scan mask.
// R17 - Alternate sampling uses Sample A, then Sample B, alternating.
// R18 - Scan steps through enabled inputs ascending, wrapping to the lowest.
module ais_top #(
	parameter int PHYS_INPUTS = 32
) (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [1:0]  conv_done,
	output logic [9:0]       pos_input,
	output logic [1:0]       pos_use_vref_neg,
	output logic [1:0]       pos_to_ground,
	output logic [1:0]       neg_use_an1,
	output logic [1:0]       sample_b_active,
	output logic [31:0]      pin_digital
);
	typedef struct packed {
		logic [1:0][15:0] chs0;
		logic [1:0][15:0] mask_hi;
		logic [1:0][15:0] mask_lo;
		logic [15:0]      pin_digital_select_hi;
		logic [1:0][15:0] pin_digital_select_lo;
		logic [15:0]      ctrl;
		logic [1:0]       phase;
		logic [1:0][4:0]  scan_cur;
		logic [9:0]       pos;
		logic [1:0]       vref;
		logic [1:0]       gnd;
		logic [1:0]       neg;
		logic [1:0]       use_b;
		logic [31:0]      pin_dig;
	} ais_state_t;

	ais_state_t q, d;
	logic              wr_en;
	logic [7:0]        wr_addr;
	logic [15:0]       wr_data;
	logic [1:0]        wr_strb;
	logic [7:0]        rd_addr;
	logic [15:0]       rd_data;
	logic [1:0][31:0]  scan_mask;
	logic [1:0][4:0]   scan_first;
	logic [1:0][4:0]   scan_next;
	logic [1:0]        scan_any;
	logic [1:0]        alt_en;
	logic [1:0]        scan_en;
	logic [1:0]        mod_dis;
	logic [1:0]        use_b;

	function automatic ais_pkg::ais_reg_t decode(input logic [7:0] a);
		unique case (a)
			`AIS_OFF_CHS0_1:  decode = ais_pkg::AIS_R_CHS0_1;
			`AIS_OFF_SCANH_1: decode = ais_pkg::AIS_R_SCANH_1;
			`AIS_OFF_SCANL_1: decode = ais_pkg::AIS_R_SCANL_1;
			`AIS_OFF_PCFGH_1: decode = ais_pkg::AIS_R_PCFGH_1;
			`AIS_OFF_PCFGL_1: decode = ais_pkg::AIS_R_PCFGL_1;
			`AIS_OFF_CHS0_2:  decode = ais_pkg::AIS_R_CHS0_2;
			`AIS_OFF_SCANH_2: decode = ais_pkg::AIS_R_SCANH_2;
			`AIS_OFF_SCANL_2: decode = ais_pkg::AIS_R_SCANL_2;
			`AIS_OFF_PCFGL_2: decode = ais_pkg::AIS_R_PCFGL_2;
			`AIS_OFF_CTRL:    decode = ais_pkg::AIS_R_CTRL;
			`AIS_OFF_STAT:    decode = ais_pkg::AIS_R_STAT;
			default:          decode = ais_pkg::AIS_R_NONE;
		endcase
	endfunction : decode

	// Byte-lane merge; the mask keeps unimplemented bits at zero
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] msk);
		merge = old;
		if (wr_strb[0])
			merge[7:0] = wr_data[7:0];
		if (wr_strb[1])
			merge[15:8] = wr_data[15:8];
		merge = merge & msk;
	endfunction : merge

	ais_axil_slave u_slave (
		.ref_clk       (ref_clk),
		.rst           (rst),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.wr_en         (wr_en),
		.wr_addr       (wr_addr),
		.wr_data       (wr_data),
		.wr_strb       (wr_strb),
		.wr_err        (decode(wr_addr) == ais_pkg::AIS_R_NONE),
		.rd_addr       (rd_addr),
		.rd_data       (rd_data),
		.rd_err        (decode(rd_addr) == ais_pkg::AIS_R_NONE)
	);

	// Second converter only scans inputs 0..15, so its high mask half is kept but unused
	assign scan_mask[0] = {q.mask_hi[0], q.mask_lo[0]};  // [R07]
	assign scan_mask[1] = {16'h0000, q.mask_lo[1]};      // [R05]

	for (genvar k = 0; k < 2; k++)
	begin : g_inst
		assign alt_en[k]  = q.ctrl[k * `AIS_CTRL_STRIDE + `AIS_CTRL_ALT];
		assign scan_en[k] = q.ctrl[k * `AIS_CTRL_STRIDE + `AIS_CTRL_SCAN];
		assign mod_dis[k] = q.ctrl[k * `AIS_CTRL_STRIDE + `AIS_CTRL_DIS];
		assign use_b[k]   = alt_en[k] && q.phase[k];
		ais_scan_step u_step (
			.mask  (scan_mask[k]),
			.cur   (q.scan_cur[k]),
			.first (scan_first[k]),
			.next  (scan_next[k]),
			.any   (scan_any[k])
		);
	end

	always_comb
	begin
		unique case (decode(rd_addr))
			ais_pkg::AIS_R_CHS0_1:  rd_data = q.chs0[0];
			ais_pkg::AIS_R_SCANH_1: rd_data = q.mask_hi[0];
			ais_pkg::AIS_R_SCANL_1: rd_data = q.mask_lo[0];
			ais_pkg::AIS_R_PCFGH_1: rd_data = q.pin_digital_select_hi;
			ais_pkg::AIS_R_PCFGL_1: rd_data = q.pin_digital_select_lo[0];
			ais_pkg::AIS_R_CHS0_2:  rd_data = q.chs0[1];
			ais_pkg::AIS_R_SCANH_2: rd_data = q.mask_hi[1];
			ais_pkg::AIS_R_SCANL_2: rd_data = q.mask_lo[1];
			ais_pkg::AIS_R_PCFGL_2: rd_data = q.pin_digital_select_lo[1];
			ais_pkg::AIS_R_CTRL:    rd_data = q.ctrl;
			ais_pkg::AIS_R_STAT:
				rd_data = {2'b00, q.phase[1], q.scan_cur[1], 2'b00, q.phase[0], q.scan_cur[0]};
			ais_pkg::AIS_R_NONE:    rd_data = 16'h0000;
		endcase
	end

	always_comb
	begin
		logic [4:0] sel;
		logic       cfg;
		logic       an1;
		logic       an2;
		sel = 5'h00;
		cfg = 1'b0;
		an1 = 1'b0;
		an2 = 1'b0;
		d   = q;
		if (wr_en)
		begin
			unique case (decode(wr_addr))
				ais_pkg::AIS_R_CHS0_1:  d.chs0[0] = merge(q.chs0[0], `AIS_CHS0_MASK_1); // [R06]
				ais_pkg::AIS_R_SCANH_1: d.mask_hi[0] = merge(q.mask_hi[0], 16'hffff);   // [R08]
				ais_pkg::AIS_R_SCANL_1: d.mask_lo[0] = merge(q.mask_lo[0], 16'hffff);
				ais_pkg::AIS_R_PCFGH_1: d.pin_digital_select_hi = merge(q.pin_digital_select_hi, 16'hffff);         // [R11]
				ais_pkg::AIS_R_PCFGL_1: d.pin_digital_select_lo[0] = merge(q.pin_digital_select_lo[0], 16'hffff);
				ais_pkg::AIS_R_CHS0_2:  d.chs0[1] = merge(q.chs0[1], `AIS_CHS0_MASK_2); // [R05]
				ais_pkg::AIS_R_SCANH_2: d.mask_hi[1] = merge(q.mask_hi[1], 16'hffff);
				ais_pkg::AIS_R_SCANL_2: d.mask_lo[1] = merge(q.mask_lo[1], 16'hffff);
				ais_pkg::AIS_R_PCFGL_2: d.pin_digital_select_lo[1] = merge(q.pin_digital_select_lo[1], 16'hffff);
				ais_pkg::AIS_R_CTRL:    d.ctrl = merge(q.ctrl, `AIS_CTRL_MASK);
				ais_pkg::AIS_R_STAT,
				ais_pkg::AIS_R_NONE:    d.ctrl = q.ctrl;
			endcase
		end
		for (int k = 0; k < 2; k++)
		begin
			// Scan applies to Sample A only; Sample B always uses its fixed field
			if (use_b[k])
				sel = q.chs0[k][`AIS_POS_B_LSB +: 5];                         // [R04] [R17]
			else if (scan_en[k] && scan_any[k])
				sel = q.scan_cur[k];                                          // [R16]
			else
				sel = q.chs0[k][`AIS_POS_A_LSB +: 5];                         // [R03]
			if (k == 1)
				sel[4] = 1'b0;                                                // [R05]
			d.pos[k * 5 +: 5] = sel;
			d.neg[k] = use_b[k] ? q.chs0[k][`AIS_NEG_B_BIT]
				: q.chs0[k][`AIS_NEG_A_BIT];                                  // [R01] [R02]
			d.use_b[k] = use_b[k];
			d.vref[k] = 32'(sel) >= PHYS_INPUTS;                              // [R08]
			if (sel[4])
				cfg = q.pin_digital_select_hi[sel[3:0]];
			else
				cfg = q.pin_digital_select_lo[k][sel[3:0]];
			d.gnd[k] = cfg || mod_dis[k];                                     // [R09] [R10]
			if (!alt_en[k])
				d.phase[k] = 1'b0;
			else if (conv_done[k] && !mod_dis[k])
				d.phase[k] = !q.phase[k];                                     // [R17]
			if (!scan_en[k])
				d.scan_cur[k] = scan_first[k];
			else if (conv_done[k] && !mod_dis[k] && !use_b[k])
				d.scan_cur[k] = scan_next[k];                                 // [R18]
		end
		// A pin below PHYS_INPUTS is analog when any enabled converter claims it as analog
		for (int i = 0; i < 32; i++)
		begin
			an1 = !mod_dis[0] && !(i < 16 ? q.pin_digital_select_lo[0][i] : q.pin_digital_select_hi[i - 16]); // [R14]
			an2 = (i < 16) && !mod_dis[1] && !q.pin_digital_select_lo[1][i % 16];            // [R12] [R13]
			d.pin_dig[i] = !((an1 || an2) && (i < PHYS_INPUTS));               // [R11]
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			q <= '0;                                                          // [R15]
		else
			q <= d;
	end

	assign pos_input        = q.pos;
	assign pos_use_vref_neg = q.vref;
	assign pos_to_ground    = q.gnd;
	assign neg_use_an1      = q.neg;
	assign sample_b_active  = q.use_b;
	assign pin_digital      = q.pin_dig;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	neg_a_route_a: assert property ($past(!use_b[0]) |-> neg_use_an1[0] == $past(q.chs0[0][7])) // [R01]
		else $error("Sample A negative select not routed");
	neg_b_route_a: assert property ($past(use_b[0]) |-> neg_use_an1[0] == $past(q.chs0[0][15])) // [R02]
		else $error("Sample B negative select not routed");
	pos_a_fixed_a: assert property (!use_b[0] && !scan_en[0] |=> pos_input[4:0] == $past(q.chs0[0][4:0])) // [R03]
		else $error("Sample A positive select wrong");
	pos_b_fixed_a: assert property (use_b[0] |=> pos_input[4:0] == $past(q.chs0[0][12:8])) // [R04]
		else $error("Sample B positive select wrong");
	second_range_a: assert property (!pos_input[9] && !q.chs0[1][12] && !q.chs0[1][4]) // [R05]
		else $error("Second converter selected above input 15");
	unused_zero_a: assert property (wr_en |=> q.chs0[0][14:13] == 2'b00 && q.chs0[0][6:5] == 2'b00) // [R06]
		else $error("Unimplemented select bits hold data");
	missing_vref_a: assert property (pos_use_vref_neg[0] == (32'(pos_input[4:0]) >= PHYS_INPUTS)) // [R08]
		else $error("Missing input not sent to negative reference");
	scan_source_a: assert property (!use_b[0] && scan_en[0] && scan_any[0] |=> pos_input[4:0] == $past(q.scan_cur[0])) // [R16]
		else $error("Scan input not used for Sample A");
	alt_toggle_a: assert property (alt_en[0] && conv_done[0] && !mod_dis[0] ##1 alt_en[0] // [R17]
		|=> sample_b_active[0] != $past(sample_b_active[0]))
		else $error("Alternate sample phase did not follow");
	scan_step_a: assert property (scan_en[0] && conv_done[0] && !mod_dis[0] && !use_b[0] |=> q.scan_cur[0] == $past(scan_next[0])) // [R18]
		else $error("Scan did not step to next enabled input");
	all_digital_a: assert property (mod_dis == 2'b11 |=> pin_digital == 32'hffffffff) // [R14]
		else $error("Disabled converters left a pin analog");
	reset_clear_a: assert property ($past(rst) |-> q.chs0 == '0 && q.pin_digital_select_lo == '0 && q.pin_digital_select_hi == 16'h0000) // [R15]
		else $error("Registers not cleared by reset");

	// Fixed Sample A select only; scan and Sample B ground routes are not checked
	pin_ground_a: assert property (!mod_dis[0] && !use_b[0] && !scan_en[0] && !q.chs0[0][4] // [R09] [R10]
		|=> pos_to_ground[0] == $past(q.pin_digital_select_lo[0][q.chs0[0][3:0]]))
		else $error("Selected input ground routing wrong");
	pin_shared_a: assert property (!mod_dis[1] && !q.pin_digital_select_lo[1][0] |=> !pin_digital[0]) // [R13]
		else $error("Second converter could not hold a shared pin analog");
endmodule : ais_top
`default_nettype wire
